// >>> rtl/dcam_params.svh
// Purpose: Constants of the dual condition alarm monitor.
// Assumes: Byte-wide register access; each 16-bit register is an
//          even/odd byte pair, low byte at the even address.
// Notes: Function
// Function
// - Two independent alarm channels, own settings each.
// - Rate window equals count times sample period.
// - Threshold bit 15 picks greater or less.
// - Threshold bits 13:0 level, bit 14 ignored.
// - Sample count low byte; zero and one mean one.
// - Alarm 2 source code in control bits 15:12.
// - Alarm 1 source code, bits 11:8, same encoding.
// - Bits 7 and 6 select rate-of-change mode.
// - Bit 4 selects filtered data for both channels.
// - Bit 2 enables the alarm output.
// - Bit 1 sets output polarity, high when set.
// - Bit 0 routes alarm to line two.
// - Alarm registers reset to zero, output off.
// - Static mode: value beyond threshold in direction.
// - Rate mode: change beyond threshold within window.
`ifndef DCAM_PARAMS_SVH
`define DCAM_PARAMS_SVH

`define DCAM_ADDR_W 7
`define DCAM_ADDR_THR1 7'h26
`define DCAM_ADDR_THR2 7'h28
`define DCAM_ADDR_SMP1 7'h2a
`define DCAM_ADDR_SMP2 7'h2c
`define DCAM_ADDR_CTRL 7'h2e

`define DCAM_RESET_VAL 16'h0000

`define DCAM_THR_POL_BIT 15
`define DCAM_THR_LVL_MSB 13
`define DCAM_SMP_MSB 7
`define DCAM_CTRL_SRC2_MSB 15
`define DCAM_CTRL_SRC2_LSB 12
`define DCAM_CTRL_SRC1_MSB 11
`define DCAM_CTRL_SRC1_LSB 8
`define DCAM_CTRL_RATE2_BIT 7
`define DCAM_CTRL_RATE1_BIT 6
`define DCAM_CTRL_FILT_BIT 4
`define DCAM_CTRL_OE_BIT 2
`define DCAM_CTRL_POL_BIT 1
`define DCAM_CTRL_LINE_BIT 0

`define DCAM_NUM_SRC 11
`define DCAM_SRC_W 16

`endif

// >>> rtl/dcam_pkg.sv
// Purpose: Types of the dual condition alarm monitor.
// Assumes: Constants come from dcam_params.svh.
// Notes: The whole block state is one packed struct.
package dcam_pkg;

    typedef enum logic [3:0] {
        DCAM_SRC_OFF = 4'h0,
        DCAM_SRC_SUPPLY = 4'h1,
        DCAM_SRC_GYRO_X = 4'h2,
        DCAM_SRC_GYRO_Y = 4'h3,
        DCAM_SRC_GYRO_Z = 4'h4,
        DCAM_SRC_ACCEL_X = 4'h5,
        DCAM_SRC_ACCEL_Y = 4'h6,
        DCAM_SRC_ACCEL_Z = 4'h7,
        DCAM_SRC_TEMP_X = 4'h8,
        DCAM_SRC_TEMP_Y = 4'h9,
        DCAM_SRC_TEMP_Z = 4'ha,
        DCAM_SRC_AUX = 4'hb
    } dcam_src_t;

    typedef struct packed {
        logic [15:0] thr1;
        logic [15:0] thr2;
        logic [15:0] smp1;
        logic [15:0] smp2;
        logic [15:0] ctrl;
        logic [1:0][16:0] ref_val;
        logic [1:0] ref_ok;
        logic [1:0][7:0] cnt;
        logic [1:0] cond;
        logic line_one;
        logic line_one_en;
        logic line_two;
        logic line_two_en;
        logic [7:0] rdata;
    } dcam_state_t;

endpackage

// >>> rtl/dcam_alarm_monitor.sv
// Purpose: Two condition alarms driving a general-purpose line.
// Assumes: Sources are refreshed on i_sample_tick, one pulse per
//          sample period; the serial port is decoded upstream into
//          byte reads and writes.
// Notes: Rate mode measures change from a reference taken at the
//        start of each window, not a sliding window, to avoid
//        storing up to 255 samples per channel.
`timescale 1ns/10ps
`include "dcam_params.svh"

module dcam_alarm_monitor #(
    parameter int SRC_W = `DCAM_SRC_W,
    parameter int NUM_SRC = `DCAM_NUM_SRC
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register byte port
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [`DCAM_ADDR_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    // Measurement sources
    input wire logic i_sample_tick,
    input wire logic [NUM_SRC*SRC_W-1:0] i_src_raw,
    input wire logic [NUM_SRC*SRC_W-1:0] i_src_filt,
    // Alarm lines
    output logic o_line_one,
    output logic o_line_one_en,
    output logic o_line_two,
    output logic o_line_two_en,
    output logic o_alarm1_active,
    output logic o_alarm2_active
);
    import dcam_pkg::*;

    generate
        if (SRC_W != `DCAM_SRC_W || NUM_SRC != `DCAM_NUM_SRC) begin : g_chk
            $error("Source width and count must match the encoding.");
        end
    endgenerate

    dcam_state_t s_q;
    dcam_state_t s_d;

    // Bring a source word to a common signed 17-bit form.
    function automatic logic [16:0] fetch_src(
        input logic [3:0] code,
        input logic use_filt,
        input logic [NUM_SRC*SRC_W-1:0] raw,
        input logic [NUM_SRC*SRC_W-1:0] filt
    );
        logic [SRC_W-1:0] w;
        logic [13:0] v;
        w = '0;
        for (int k = 0; k < NUM_SRC; k++) begin
            if (code == 4'(k + 1)) begin
                w = use_filt ? filt[k*SRC_W +: SRC_W] : raw[k*SRC_W +: SRC_W];
            end
        end
        v = w[13:0];
        if (code >= DCAM_SRC_GYRO_X && code <= DCAM_SRC_TEMP_Z) begin
            fetch_src = {{3{v[13]}}, v};
        end else begin
            fetch_src = {3'h0, v};
        end
    endfunction

    // Threshold level in the same form as its source.
    function automatic logic [16:0] fetch_thr(
        input logic [3:0] code,
        input logic [15:0] thr
    );
        logic [13:0] v;
        v = thr[`DCAM_THR_LVL_MSB:0];
        if (code >= DCAM_SRC_GYRO_X && code <= DCAM_SRC_TEMP_Z) begin
            fetch_thr = {{3{v[13]}}, v};
        end else begin
            fetch_thr = {3'h0, v};
        end
    endfunction

    logic [1:0][3:0] src_code;
    logic [1:0] rate_mode;
    logic [1:0][15:0] thr_reg;
    logic [1:0][15:0] smp_reg;

    always_comb begin
        src_code[1] = s_q.ctrl[`DCAM_CTRL_SRC2_MSB:`DCAM_CTRL_SRC2_LSB];
        src_code[0] = s_q.ctrl[`DCAM_CTRL_SRC1_MSB:`DCAM_CTRL_SRC1_LSB];
        rate_mode[1] = s_q.ctrl[`DCAM_CTRL_RATE2_BIT];
        rate_mode[0] = s_q.ctrl[`DCAM_CTRL_RATE1_BIT];
        thr_reg[0] = s_q.thr1;
        thr_reg[1] = s_q.thr2;
        smp_reg[0] = s_q.smp1;
        smp_reg[1] = s_q.smp2;
    end

    always_comb begin
        logic [16:0] cur;
        logic [16:0] lvl;
        logic [16:0] cmp;
        logic [7:0] win;
        logic hit;
        logic any;
        logic act;
        cur = '0;
        lvl = '0;
        cmp = '0;
        win = '0;
        hit = 1'b0;
        any = 1'b0;
        act = 1'b0;
        s_d = s_q;

        // Byte writes land in the matching half of a register.
        if (i_reg_wr) begin
            case (i_reg_addr)
                `DCAM_ADDR_THR1: s_d.thr1[7:0] = i_reg_wdata;
                `DCAM_ADDR_THR1 + 7'h01: s_d.thr1[15:8] = i_reg_wdata;
                `DCAM_ADDR_THR2: s_d.thr2[7:0] = i_reg_wdata;
                `DCAM_ADDR_THR2 + 7'h01: s_d.thr2[15:8] = i_reg_wdata;
                `DCAM_ADDR_SMP1: s_d.smp1[7:0] = i_reg_wdata;
                `DCAM_ADDR_SMP1 + 7'h01: s_d.smp1[15:8] = i_reg_wdata;
                `DCAM_ADDR_SMP2: s_d.smp2[7:0] = i_reg_wdata;
                `DCAM_ADDR_SMP2 + 7'h01: s_d.smp2[15:8] = i_reg_wdata;
                `DCAM_ADDR_CTRL: s_d.ctrl[7:0] = i_reg_wdata;
                `DCAM_ADDR_CTRL + 7'h01: s_d.ctrl[15:8] = i_reg_wdata;
                default: ;
            endcase
        end

        // Unmapped byte addresses read as zero.
        if (i_reg_rd) begin
            case (i_reg_addr)
                `DCAM_ADDR_THR1: s_d.rdata = s_q.thr1[7:0];
                `DCAM_ADDR_THR1 + 7'h01: s_d.rdata = s_q.thr1[15:8];
                `DCAM_ADDR_THR2: s_d.rdata = s_q.thr2[7:0];
                `DCAM_ADDR_THR2 + 7'h01: s_d.rdata = s_q.thr2[15:8];
                `DCAM_ADDR_SMP1: s_d.rdata = s_q.smp1[7:0];
                `DCAM_ADDR_SMP1 + 7'h01: s_d.rdata = s_q.smp1[15:8];
                `DCAM_ADDR_SMP2: s_d.rdata = s_q.smp2[7:0];
                `DCAM_ADDR_SMP2 + 7'h01: s_d.rdata = s_q.smp2[15:8];
                `DCAM_ADDR_CTRL: s_d.rdata = s_q.ctrl[7:0];
                `DCAM_ADDR_CTRL + 7'h01: s_d.rdata = s_q.ctrl[15:8];
                default: s_d.rdata = 8'h00;
            endcase
        end

        // Each channel is evaluated once per sample on its own settings.
        for (int c = 0; c < 2; c++) begin
            cur = fetch_src(src_code[c], s_q.ctrl[`DCAM_CTRL_FILT_BIT],
                i_src_raw, i_src_filt);
            lvl = fetch_thr(src_code[c], thr_reg[c]);
            win = (smp_reg[c][`DCAM_SMP_MSB:0] == 8'h00) ? 8'h01
                : smp_reg[c][`DCAM_SMP_MSB:0];
            if (src_code[c] == DCAM_SRC_OFF || src_code[c] > DCAM_SRC_AUX) begin
                s_d.cond[c] = 1'b0;
                s_d.ref_ok[c] = 1'b0;
                s_d.cnt[c] = 8'h00;
            end else if (i_sample_tick) begin
                cmp = rate_mode[c] ? 17'(cur - s_q.ref_val[c]) : cur;
                if (thr_reg[c][`DCAM_THR_POL_BIT]) begin
                    hit = $signed(cmp) > $signed(lvl);
                end else begin
                    hit = $signed(cmp) < $signed(lvl);
                end
                // A rate check needs one reference sample first.
                s_d.cond[c] = hit && (!rate_mode[c] || s_q.ref_ok[c]);
                if (!s_q.ref_ok[c] || 8'(s_q.cnt[c] + 8'h01) >= win) begin
                    s_d.ref_val[c] = cur;
                    s_d.ref_ok[c] = 1'b1;
                    s_d.cnt[c] = 8'h00;
                end else begin
                    s_d.cnt[c] = 8'(s_q.cnt[c] + 8'h01);
                end
            end
        end

        any = s_q.cond[0] | s_q.cond[1];
        act = s_q.ctrl[`DCAM_CTRL_POL_BIT] ? any : ~any;
        if (s_q.ctrl[`DCAM_CTRL_OE_BIT]) begin
            s_d.line_two_en = s_q.ctrl[`DCAM_CTRL_LINE_BIT];
            s_d.line_one_en = ~s_q.ctrl[`DCAM_CTRL_LINE_BIT];
            s_d.line_two = s_q.ctrl[`DCAM_CTRL_LINE_BIT] & act;
            s_d.line_one = ~s_q.ctrl[`DCAM_CTRL_LINE_BIT] & act;
        end else begin
            s_d.line_one_en = 1'b0;
            s_d.line_two_en = 1'b0;
            s_d.line_one = 1'b0;
            s_d.line_two = 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            s_q <= '0;
            s_q.thr1 <= `DCAM_RESET_VAL;
            s_q.thr2 <= `DCAM_RESET_VAL;
            s_q.smp1 <= `DCAM_RESET_VAL;
            s_q.smp2 <= `DCAM_RESET_VAL;
            s_q.ctrl <= `DCAM_RESET_VAL;
        end else begin
            s_q <= s_d;
        end
    end

    assign o_reg_rdata = s_q.rdata;
    assign o_line_one = s_q.line_one;
    assign o_line_one_en = s_q.line_one_en;
    assign o_line_two = s_q.line_two;
    assign o_line_two_en = s_q.line_two_en;
    assign o_alarm1_active = s_q.cond[0];
    assign o_alarm2_active = s_q.cond[1];

endmodule

// >>> dv/dcam_host.sv
// Purpose: Host model writing and reading alarm registers by byte.
// Assumes: Strobes are set and released on falling clock edges.
// Notes: An idle cycle follows every byte, so strobes never retoggle.
`timescale 1ns/10ps
module dcam_host (
    input wire logic i_clk_sys,
    output logic o_wr,
    output logic o_rd,
    output logic [6:0] o_addr,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata
);
    initial {o_wr, o_rd, o_addr, o_wdata} = '0;
    task wr8(input logic [6:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        {o_wr, o_addr, o_wdata} = {1'b1, a, d};
        @(negedge i_clk_sys);
        o_wr = 1'b0;
    endtask
    task wr16(input logic [6:0] a, input logic [15:0] d);
        wr8(a | 7'h01, d[15:8]);
        wr8(a, d[7:0]);
    endtask
    task rd8(input logic [6:0] a, output logic [7:0] d);
        @(negedge i_clk_sys);
        {o_rd, o_addr} = {1'b1, a};
        @(negedge i_clk_sys);
        o_rd = 1'b0;
        d = i_rdata;
    endtask
endmodule

// >>> dv/dcam_chk.sv
// Purpose: Port assertions of the alarm monitor.
// Assumes: Control register is shadowed from byte writes.
// Notes: Line output checks wait three quiet cycles after any write, alarm checks two.
`timescale 1ns/10ps
`include "dcam_params.svh"
module dcam_chk (
    input wire logic i_clk_sys, i_rst, i_reg_wr, i_reg_rd,
    input wire logic [`DCAM_ADDR_W-1:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata, o_reg_rdata,
    input wire logic i_sample_tick, o_line_one, o_line_one_en,
    input wire logic o_line_two, o_line_two_en,
    input wire logic o_alarm1_active, o_alarm2_active
);
    logic [15:0] c_q;
    logic [1:0] st_q;
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            c_q <= 16'h0000;
            st_q <= 2'h0;
        end else begin
            if (i_reg_wr && i_reg_addr == 7'h2e) c_q[7:0] <= i_reg_wdata;
            if (i_reg_wr && i_reg_addr == 7'h2f) c_q[15:8] <= i_reg_wdata;
            st_q <= i_reg_wr ? 2'h0 : st_q + {1'b0, st_q != 2'h3};
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    a_reset_out: assert property (disable iff (1'b0) i_rst |=>
        !(o_line_one_en | o_line_two_en | o_alarm1_active |
        o_alarm2_active) && o_reg_rdata == 8'h00) else $error("reset out");
    a_out_off: assert property (st_q == 2'h3 && !c_q[2] |->
        !(o_line_one | o_line_one_en | o_line_two | o_line_two_en))
        else $error("output not off");
    a_line_sel: assert property (st_q == 2'h3 && c_q[2] |->
        o_line_two_en == c_q[0] && o_line_one_en == !c_q[0] &&
        !(c_q[0] ? o_line_one : o_line_two)) else $error("line select");
    a_pol_level: assert property (st_q == 2'h3 && c_q[2] |->
        (c_q[0] ? o_line_two : o_line_one) == (($past(o_alarm1_active) |
        $past(o_alarm2_active)) ~^ c_q[1])) else $error("line level");
    a_src1_off: assert property (st_q[1] &&
        (c_q[11:8] == 4'h0 || c_q[11:8] > 4'hb) |-> !o_alarm1_active)
        else $error("alarm 1 not off");
    a_src2_off: assert property (st_q[1] &&
        (c_q[15:12] == 4'h0 || c_q[15:12] > 4'hb) |-> !o_alarm2_active)
        else $error("alarm 2 not off");
    a_tick_cause: assert property ($changed(o_alarm1_active) ||
        $changed(o_alarm2_active) |-> $past(i_sample_tick) || !st_q[1])
        else $error("alarm moved without tick");
    a_rd_ctrl: assert property (i_reg_rd && !i_reg_wr &&
        i_reg_addr == 7'h2e |=> o_reg_rdata == c_q[7:0])
        else $error("control readback");
endmodule
bind dcam_alarm_monitor dcam_chk u_chk (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .i_sample_tick(i_sample_tick),
    .o_line_one(o_line_one), .o_line_one_en(o_line_one_en),
    .o_line_two(o_line_two), .o_line_two_en(o_line_two_en),
    .o_alarm1_active(o_alarm1_active), .o_alarm2_active(o_alarm2_active));

// >>> dv/tb_top.sv
// Purpose: Self-checking bench of the alarm monitor.
// Assumes: Inputs change on the falling clock edge.
// Notes: Rate windows are modelled as blocks from a captured reference.
`timescale 1ns/10ps
`include "dcam_params.svh"
module tb_top;
    localparam int W = `DCAM_NUM_SRC * `DCAM_SRC_W;
    logic clk = 1'b0, rst = 1'b1, tick = 1'b0;
    logic [W-1:0] raw = '0, filt = '0;
    logic wr, rd, l1, l1e, l2, l2e, a1, a2, e;
    logic [6:0] addr;
    logic [7:0] wd, rdat, r;
    logic [15:0] ctl, t1, t2;
    logic [3:0] c1, c2;
    logic signed [16:0] rv, v;
    logic [1:0] g;
    int seed = 32'h6923ef67, n_mismatch = 0, total_checks = 0, cnt;
    int ns[4] = '{0, 1, 3, 8};
    dcam_alarm_monitor dut (.i_clk_sys(clk), .i_rst(rst), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
        .o_reg_rdata(rdat), .i_sample_tick(tick), .i_src_raw(raw),
        .i_src_filt(filt), .o_line_one(l1), .o_line_one_en(l1e),
        .o_line_two(l2), .o_line_two_en(l2e), .o_alarm1_active(a1),
        .o_alarm2_active(a2));
    dcam_host host (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wd), .i_rdata(rdat));
    function automatic logic signed [16:0] ext(input logic [3:0] c,
        input logic [15:0] w);
        return (c >= 4'h2 && c <= 4'ha) ? {{3{w[13]}}, w[13:0]} :
            {3'h0, w[13:0]};
    endfunction
    function automatic logic hit(input logic p,
        input logic signed [16:0] d, t);
        return p ? d > t : d < t;
    endfunction
    function automatic logic [15:0] src(input logic [3:0] c, input logic f);
        return f ? filt[(int'(c) - 1) * 16 +: 16] : raw[(int'(c) - 1) * 16 +: 16];
    endfunction
    function automatic logic stat(input logic [3:0] c,
        input logic [15:0] t, input logic f);
        return (c == 4'h0 || c > 4'hb) ? 1'b0 :
            hit(t[15], ext(c, src(c, f)), ext(c, t));
    endfunction
    function automatic logic [3:0] lines(input logic [15:0] c,
        input logic a);
        logic lv;
        lv = c[1] ? a : !a;
        if (!c[2]) return 4'h0;
        return c[0] ? {1'b1, lv, 2'b00} : {2'b00, 1'b1, lv};
    endfunction
    task chk(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task rnd_src;
        for (int k = 0; k < W / 16; k++) begin
            raw[k*16 +: 16] = $random(seed);
            filt[k*16 +: 16] = $random(seed);
        end
    endtask
    task do_tick;
        @(negedge clk) tick = 1'b1;
        @(negedge clk) tick = 1'b0;
        g = {a2, a1};
    endtask
    initial forever #20 clk = ~clk;
    initial begin
        #200000;
        n_mismatch++;
        final_report;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst = 1'b0;
        for (int a = 'h26; a <= 'h30; a++) begin
            host.rd8(7'(a), r);
            chk(r, 0);
        end
        for (int i = 0; i < 60; i++) begin
            ctl = $random(seed);
            ctl[7:6] = 2'h0;
            ctl[11:8] = 4'(1 + {$random(seed)} % 11);
            {t1, t2} = $random(seed);
            {c1, c2} = {ctl[11:8], ctl[15:12]};
            host.wr16(7'h2e, ctl);
            host.wr16(7'h26, t1);
            host.wr16(7'h28, t2);
            host.rd8(7'h27, r);
            chk(r, t1[15:8]);
            @(negedge clk) rnd_src;
            if (i % 4 == 0) raw[(int'(c1) - 1) * 16 +: 16] = t1;
            if (i % 4 == 0) filt[(int'(c1) - 1) * 16 +: 16] = t1;
            do_tick;
            chk(g[0], stat(c1, t1, ctl[4]));
            chk(g[1], stat(c2, t2, ctl[4]));
            @(negedge clk);
            chk({l2e, l2, l1e, l1}, lines(ctl, stat(c1, t1, ctl[4]) |
                stat(c2, t2, ctl[4])));
        end
        for (int k = 0; k < 4; k++) begin
            @(negedge clk) rst = 1'b1;
            repeat (2) @(negedge clk);
            rst = 1'b0;
            c1 = 4'(1 + {$random(seed)} % 11);
            t1 = $random(seed);
            ctl = k[0] ? {c1, 12'h086} : {4'h0, c1, 8'h46};
            host.wr16(7'h2e, ctl);
            host.wr16(k[0] ? 7'h28 : 7'h26, t1);
            host.wr16(k[0] ? 7'h2c : 7'h2a, {8'($random(seed)), 8'(ns[k])});
            cnt = 0;
            for (int j = 0; j < 12; j++) begin
                @(negedge clk) rnd_src;
                v = ext(c1, src(c1, 1'b0));
                e = (j == 0) ? 1'b0 : hit(t1[15], v - rv, ext(c1, t1));
                if (j == 0 || cnt + 1 >= ns[k]) {rv, cnt} = {v, 32'd0};
                else cnt++;
                do_tick;
                chk(g[k[0]], e);
                chk(g[!k[0]], 0);
            end
        end
        final_report;
    end
endmodule
